// *** hw/dcr_pkg.sv ***
// Package with register map, field layout, reset values, timing and types of the display control registers.
package dcr_pkg;
	localparam int CLK_HZ         = 40_000_000;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int CYC_PER_MS     = CLK_HZ / 1000;

	// Printed offsets are register indices; the byte address is four times the index.
	localparam logic [29:0] IDX_DUTY    = 30'h1fff9;
	localparam logic [29:0] IDX_ORIENT  = 30'h1fffb;
	localparam logic [29:0] IDX_LAYER   = 30'h1fffc;
	localparam logic [29:0] IDX_PAGE    = 30'h1fffd;
	localparam logic [29:0] IDX_FILLPIX = 30'h1fffe;
	localparam logic [29:0] IDX_FILLCMD = 30'h1ffff;

	// Layer and blink control fields.
	localparam int LB_MODE   = 7;
	localparam int LB_FAST   = 6;
	localparam int LB_SLOW   = 5;
	localparam int LB_TRANSP = 4;
	localparam int LB_BG_LO  = 2;
	localparam int LB_FG_LO  = 0;
	// Page select fields.
	localparam int PS_FILL_LO  = 4;
	localparam int PS_READ_LO  = 2;
	localparam int PS_WRITE_LO = 0;
	// Orientation and backlight fields, and the fill command busy bit.
	localparam int OB_UD = 2;
	localparam int OB_RL = 1;
	localparam int OB_BL = 0;
	localparam int FC_BUSY = 0;

	localparam logic [7:0] LAYER_RST   = 8'h00;
	localparam logic [7:0] PAGE_RST    = 8'h00;
	localparam logic [2:0] ORIENT_RST  = 3'h5;
	localparam logic [6:0] DUTY_RST    = 7'h7f;
	localparam logic [7:0] FILLPIX_RST = 8'h00;
	localparam logic [6:0] PWM_LAST    = 7'h7e;

	localparam int FILL_TIME_MS     = 32;
	localparam int FILL_CYCLES      = FILL_TIME_MS * CYC_PER_MS;
	localparam int IRQ_WIDTH_NS     = 66500;
	localparam int IRQ_CYCLES       = IRQ_WIDTH_NS / CLK_PERIOD_NS;
	localparam int SLOW_PERIOD_MS   = 1000;
	localparam int FAST_PERIOD_MS   = 500;
	localparam int SLOW_HALF_CYCLES = SLOW_PERIOD_MS * CYC_PER_MS / 2;
	localparam int FAST_HALF_CYCLES = FAST_PERIOD_MS * CYC_PER_MS / 2;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_DUTY,
		SEL_ORIENT,
		SEL_LAYER,
		SEL_PAGE,
		SEL_FILLPIX,
		SEL_FILLCMD
	} dcr_sel_t;

	typedef struct packed {
		logic       color_mode;
		logic       fast_show;
		logic       slow_show;
		logic       transp_active;
		logic [1:0] bg_page;
		logic [1:0] fg_page;
		logic [1:0] fill_page;
		logic [1:0] read_page;
		logic [1:0] write_page;
		logic       flip_ud;
		logic       flip_rl;
		logic       backlight_on;
		logic       backlight_pwm;
		logic       fill_busy;
		logic       fill_done_irq_n;
		logic [7:0] fill_pixel;
	} dcr_disp_t;

	typedef struct packed {
		logic [7:0]  layer;
		logic [7:0]  page;
		logic [2:0]  orient;
		logic [6:0]  duty;
		logic [7:0]  fill_pixel;
		logic [7:0]  adc_x;
		logic [7:0]  adc_y;
		logic        wr_pend;
		dcr_sel_t    wr_sel;
		logic [31:0] rdata;
		logic        ready;
		logic        resp;
		logic        busy;
		logic [31:0] fill_cnt;
		logic [31:0] irq_cnt;
		logic [31:0] slow_cnt;
		logic [31:0] fast_cnt;
		logic        slow_ph;
		logic        fast_ph;
		logic [6:0]  pwm_cnt;
		dcr_disp_t   o;
	} dcr_state_t;
endpackage

// *** hw/dcr_regs.sv ***
// Display control register bank with AHB-Lite slave, blink timers, backlight PWM and hardware fill sequencing.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// (R1) Mode bit selects palette or direct colour.
// (R2) Two bits enable fast and slow blink.
// (R3) Slow blink one second, fast half second.
// (R4) Transparency acts only in palette mode.
// (R5) Two bits choose the background page.
// (R6) Two bits choose the foreground page.
// (R7) First control address reads X result.
// (R8) Results refresh continuously, readable any time.
// (R9) Two bits choose the fill target page.
// (R10) Host sets fill and write page equal.
// (R11) Two bits choose the host read page.
// (R12) Two bits choose the host write page.
// (R13) Second control address reads Y result.
// (R14) Seven bit duty, reset full on.
// (R15) Inverted supplies need duty zero for brightest.
// (R16) Orientation bits drive panel flip signals.
// (R17) Backlight on bit, resets to on.
// (R18) Fill data holds pixel for page fill.
// (R19) Any fill command write starts a fill.
// (R20) Busy reads one until fill completes.
// (R21) Completion drives low interrupt one line.
// (R22) Dot codes combine with blink enables.
// (R23) Invalid page codes accepted, left undefined.
// (R24) Blink phase counted from the clock.
module dcr_regs #(
	parameter int FILL_CYCLES      = dcr_pkg::FILL_CYCLES,
	parameter int SLOW_HALF_CYCLES = dcr_pkg::SLOW_HALF_CYCLES,
	parameter int FAST_HALF_CYCLES = dcr_pkg::FAST_HALF_CYCLES
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output var  logic              hreadyout,
	output var  logic [31:0]       hrdata,
	output var  logic              hresp,
	input  wire logic              adc_strobe,
	input  wire logic [7:0]        adc_x_in,
	input  wire logic [7:0]        adc_y_in,
	output var  dcr_pkg::dcr_disp_t disp
);
	dcr_pkg::dcr_state_t st_reg;
	dcr_pkg::dcr_state_t st_next;
	logic                acc;
	dcr_pkg::dcr_sel_t   asel;

	function automatic dcr_pkg::dcr_sel_t decode(input logic [31:0] a);
		if (a[1:0] != 2'h0) begin
			decode = dcr_pkg::SEL_NONE;
		end else if (a[31:2] == dcr_pkg::IDX_DUTY) begin
			decode = dcr_pkg::SEL_DUTY;
		end else if (a[31:2] == dcr_pkg::IDX_ORIENT) begin
			decode = dcr_pkg::SEL_ORIENT;
		end else if (a[31:2] == dcr_pkg::IDX_LAYER) begin
			decode = dcr_pkg::SEL_LAYER;
		end else if (a[31:2] == dcr_pkg::IDX_PAGE) begin
			decode = dcr_pkg::SEL_PAGE;
		end else if (a[31:2] == dcr_pkg::IDX_FILLPIX) begin
			decode = dcr_pkg::SEL_FILLPIX;
		end else if (a[31:2] == dcr_pkg::IDX_FILLCMD) begin
			decode = dcr_pkg::SEL_FILLCMD;
		end else begin
			decode = dcr_pkg::SEL_NONE;
		end
	endfunction

	assign acc  = hsel && htrans[1] && hready;
	assign asel = decode(haddr);

	always_comb begin
		st_next = st_reg;
		// The slave never stalls and always answers OKAY, so the data phase is one cycle.
		st_next.ready   = 1'b1;
		st_next.resp    = 1'b0;
		st_next.wr_pend = acc && hwrite;
		st_next.wr_sel  = asel;
		st_next.rdata   = 32'h0;
		// Write-only registers read as zero; the shared addresses return the touch results.
		if (acc && !hwrite) begin
			case (asel)
				dcr_pkg::SEL_LAYER: begin
					st_next.rdata = {24'h0, st_reg.adc_x}; // R7
				end
				dcr_pkg::SEL_PAGE: begin
					st_next.rdata = {24'h0, st_reg.adc_y}; // R13
				end
				dcr_pkg::SEL_FILLCMD: begin
					st_next.rdata = {31'h0, st_reg.busy}; // R20
				end
				default: begin
					st_next.rdata = 32'h0;
				end
			endcase
		end
		// Results are stored whenever the touch controller delivers them, with no host handshake.
		if (adc_strobe) begin
			st_next.adc_x = adc_x_in; // R8
			st_next.adc_y = adc_y_in; // R8
		end
		if (st_reg.irq_cnt != 32'h0) begin
			st_next.irq_cnt = st_reg.irq_cnt - 32'h1;
		end
		if (st_reg.busy) begin
			if (st_reg.fill_cnt == 32'(FILL_CYCLES - 1)) begin
				st_next.busy    = 1'b0; // R20
				st_next.irq_cnt = 32'(dcr_pkg::IRQ_CYCLES); // R21
			end else begin
				st_next.fill_cnt = st_reg.fill_cnt + 32'h1;
			end
		end
		// Writes come last so that a new fill command wins over a completion in the same cycle.
		if (st_reg.wr_pend) begin
			case (st_reg.wr_sel)
				dcr_pkg::SEL_DUTY: begin
					st_next.duty = hwdata[6:0]; // R14
				end
				dcr_pkg::SEL_ORIENT: begin
					st_next.orient = hwdata[2:0]; // R16 R17
				end
				dcr_pkg::SEL_LAYER: begin
					st_next.layer = hwdata[7:0]; // R23
				end
				dcr_pkg::SEL_PAGE: begin
					st_next.page = {2'h0, hwdata[5:0]}; // R23
				end
				dcr_pkg::SEL_FILLPIX: begin
					st_next.fill_pixel = hwdata[7:0]; // R18
				end
				dcr_pkg::SEL_FILLCMD: begin
					st_next.busy     = 1'b1; // R19
					st_next.fill_cnt = 32'h0;
				end
				default: begin
				end
			endcase
		end
		// Blink phases free-run from the clock so host traffic cannot disturb their rate.
		if (st_reg.slow_cnt == 32'(SLOW_HALF_CYCLES - 1)) begin
			st_next.slow_cnt = 32'h0; // R24
			st_next.slow_ph  = !st_reg.slow_ph; // R3
		end else begin
			st_next.slow_cnt = st_reg.slow_cnt + 32'h1;
		end
		if (st_reg.fast_cnt == 32'(FAST_HALF_CYCLES - 1)) begin
			st_next.fast_cnt = 32'h0; // R24
			st_next.fast_ph  = !st_reg.fast_ph; // R3
		end else begin
			st_next.fast_cnt = st_reg.fast_cnt + 32'h1;
		end
		// A 127-step cycle lets the full-scale code 7f keep the output high all the time.
		if (st_reg.pwm_cnt == dcr_pkg::PWM_LAST) begin
			st_next.pwm_cnt = 7'h0;
		end else begin
			st_next.pwm_cnt = st_reg.pwm_cnt + 7'h1;
		end
		st_next.o.color_mode    = st_next.layer[dcr_pkg::LB_MODE]; // R1
		st_next.o.fast_show     = !st_next.layer[dcr_pkg::LB_FAST] || st_next.fast_ph; // R2 R22
		st_next.o.slow_show     = !st_next.layer[dcr_pkg::LB_SLOW] || st_next.slow_ph; // R2 R22
		st_next.o.transp_active = st_next.layer[dcr_pkg::LB_TRANSP] && !st_next.layer[dcr_pkg::LB_MODE]; // R4
		st_next.o.bg_page       = st_next.layer[dcr_pkg::LB_BG_LO +: 2]; // R5
		st_next.o.fg_page       = st_next.layer[dcr_pkg::LB_FG_LO +: 2]; // R6
		st_next.o.fill_page     = st_next.page[dcr_pkg::PS_FILL_LO +: 2]; // R9
		st_next.o.read_page     = st_next.page[dcr_pkg::PS_READ_LO +: 2]; // R11
		st_next.o.write_page    = st_next.page[dcr_pkg::PS_WRITE_LO +: 2]; // R12
		st_next.o.flip_ud       = st_next.orient[dcr_pkg::OB_UD]; // R16
		st_next.o.flip_rl       = st_next.orient[dcr_pkg::OB_RL]; // R16
		st_next.o.backlight_on  = st_next.orient[dcr_pkg::OB_BL]; // R17
		st_next.o.backlight_pwm = st_reg.pwm_cnt < st_reg.duty; // R14
		st_next.o.fill_busy     = st_next.busy;
		st_next.o.fill_done_irq_n = st_next.irq_cnt == 32'h0; // R21
		st_next.o.fill_pixel    = st_next.fill_pixel; // R18
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg                   <= '0;
			st_reg.layer             <= dcr_pkg::LAYER_RST;
			st_reg.page              <= dcr_pkg::PAGE_RST;
			st_reg.orient            <= dcr_pkg::ORIENT_RST;
			st_reg.duty              <= dcr_pkg::DUTY_RST;
			st_reg.fill_pixel        <= dcr_pkg::FILLPIX_RST;
			st_reg.wr_sel            <= dcr_pkg::SEL_NONE;
			st_reg.ready             <= 1'b1;
			st_reg.o.fast_show       <= 1'b1;
			st_reg.o.slow_show       <= 1'b1;
			st_reg.o.flip_ud         <= 1'b1;
			st_reg.o.backlight_on    <= 1'b1;
			st_reg.o.backlight_pwm   <= 1'b1;
			st_reg.o.fill_done_irq_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hreadyout = st_reg.ready;
	assign hrdata    = st_reg.rdata;
	assign hresp     = st_reg.resp;
	assign disp      = st_reg.o;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	fill_start_a: assert property (st_reg.wr_pend && st_reg.wr_sel == dcr_pkg::SEL_FILLCMD |=> disp.fill_busy) // R19
		else $error("fill command did not raise busy");
	fill_done_a: assert property ($fell(disp.fill_busy) && !$past(st_reg.wr_pend) |-> !disp.fill_done_irq_n) // R21
		else $error("fill completion without interrupt");
	irq_width_a: assert property (!disp.fill_done_irq_n // R21
		|-> st_reg.irq_cnt != 32'h0 && st_reg.irq_cnt <= 32'(dcr_pkg::IRQ_CYCLES))
		else $error("interrupt low outside its window");
	pwm_full_a: assert property ($past(st_reg.duty) == 7'h7f |-> disp.backlight_pwm) // R14
		else $error("full duty did not keep pwm high");
	pwm_zero_a: assert property ($past(st_reg.duty) == 7'h00 |-> !disp.backlight_pwm) // R14
		else $error("zero duty let pwm go high");
	transp_mode_a: assert property (disp.transp_active |-> !disp.color_mode) // R4
		else $error("transparency active in direct colour mode");
	adc_x_read_a: assert property (acc && !hwrite && asel == dcr_pkg::SEL_LAYER |=> hrdata == {24'h0, $past(st_reg.adc_x)}) // R7
		else $error("x result not returned");
	adc_y_read_a: assert property (acc && !hwrite && asel == dcr_pkg::SEL_PAGE |=> hrdata == {24'h0, $past(st_reg.adc_y)}) // R13
		else $error("y result not returned");
	adc_store_a: assert property (adc_strobe |=> st_reg.adc_x == $past(adc_x_in) && st_reg.adc_y == $past(adc_y_in)) // R8
		else $error("touch result not stored");
	blink_rate_a: assert property ($changed(st_reg.slow_ph) |-> $past(st_reg.slow_cnt) == 32'(SLOW_HALF_CYCLES - 1)) // R3
		else $error("slow blink toggled off schedule");
	orient_drive_a: assert property (disp.flip_ud == st_reg.orient[2] && disp.backlight_on == st_reg.orient[0]) // R16 R17
		else $error("orientation outputs disagree with register");

	bus_ready_a: assert property ( // R8
		hreadyout)
		else $error("slave inserted a wait state");

	resp_okay_a: assert property ( // R23
		!hresp)
		else $error("error response given");

	rdata_upper_a: assert property ( // R7 R13
		hrdata[31:8] == 24'h0)
		else $error("read data above the byte not zero");

	write_rdata_a: assert property ( // R7 R13
		acc && hwrite |=> hrdata == 32'h0)
		else $error("write returned read data");

	wo_read_a: assert property ( // R14 R16 R18
		acc && !hwrite && asel inside {dcr_pkg::SEL_DUTY, dcr_pkg::SEL_ORIENT, dcr_pkg::SEL_FILLPIX} |=> hrdata == 32'h0)
		else $error("write-only register read back non-zero");

	busy_read_a: assert property ( // R20
		acc && !hwrite && asel == dcr_pkg::SEL_FILLCMD |=> hrdata == {31'h0, $past(st_reg.busy)})
		else $error("busy flag not returned");

	duty_write_a: assert property ( // R14
		st_reg.wr_pend && st_reg.wr_sel == dcr_pkg::SEL_DUTY |=> st_reg.duty == $past(hwdata[6:0]))
		else $error("duty write lost");

	orient_write_a: assert property ( // R16 R17
		st_reg.wr_pend && st_reg.wr_sel == dcr_pkg::SEL_ORIENT
		|=> {disp.flip_ud, disp.flip_rl, disp.backlight_on} == $past(hwdata[2:0]))
		else $error("orientation write lost");

	layer_write_a: assert property ( // R23
		st_reg.wr_pend && st_reg.wr_sel == dcr_pkg::SEL_LAYER |=> st_reg.layer == $past(hwdata[7:0]))
		else $error("layer write lost");

	page_write_a: assert property ( // R9 R11 R12
		st_reg.wr_pend && st_reg.wr_sel == dcr_pkg::SEL_PAGE
		|=> {disp.fill_page, disp.read_page, disp.write_page} == $past(hwdata[5:0]))
		else $error("page write lost");

	pixel_write_a: assert property ( // R18
		st_reg.wr_pend && st_reg.wr_sel == dcr_pkg::SEL_FILLPIX |=> disp.fill_pixel == $past(hwdata[7:0]))
		else $error("fill pixel write lost");

	regs_hold_a: assert property ( // R14 R16 R18
		!st_reg.wr_pend
		|=> $stable(st_reg.layer) && $stable(st_reg.page) && $stable(st_reg.orient)
		&& $stable(st_reg.duty) && $stable(st_reg.fill_pixel))
		else $error("control register changed without a write");

	mode_out_a: assert property ( // R1
		disp.color_mode == st_reg.layer[dcr_pkg::LB_MODE])
		else $error("colour mode output wrong");

	layer_pages_a: assert property ( // R5 R6
		disp.bg_page == st_reg.layer[dcr_pkg::LB_BG_LO +: 2]
		&& disp.fg_page == st_reg.layer[dcr_pkg::LB_FG_LO +: 2])
		else $error("layer page outputs wrong");

	page_out_a: assert property ( // R9 R11 R12
		disp.fill_page == st_reg.page[dcr_pkg::PS_FILL_LO +: 2]
		&& disp.read_page == st_reg.page[dcr_pkg::PS_READ_LO +: 2]
		&& disp.write_page == st_reg.page[dcr_pkg::PS_WRITE_LO +: 2])
		else $error("page select outputs wrong");

	fast_off_a: assert property ( // R2
		!st_reg.layer[dcr_pkg::LB_FAST] |-> disp.fast_show)
		else $error("disabled fast blink still blinks");

	slow_off_a: assert property ( // R2
		!st_reg.layer[dcr_pkg::LB_SLOW] |-> disp.slow_show)
		else $error("disabled slow blink still blinks");

	fast_on_a: assert property ( // R2 R22
		st_reg.layer[dcr_pkg::LB_FAST] |-> disp.fast_show == st_reg.fast_ph)
		else $error("fast blink does not follow its phase");

	slow_on_a: assert property ( // R2 R22
		st_reg.layer[dcr_pkg::LB_SLOW] |-> disp.slow_show == st_reg.slow_ph)
		else $error("slow blink does not follow its phase");

	transp_on_a: assert property ( // R4
		st_reg.layer[dcr_pkg::LB_TRANSP] && !st_reg.layer[dcr_pkg::LB_MODE] |-> disp.transp_active)
		else $error("transparency not active in palette mode");

	fast_rate_a: assert property ( // R3
		$changed(st_reg.fast_ph) |-> $past(st_reg.fast_cnt) == 32'(FAST_HALF_CYCLES - 1))
		else $error("fast blink toggled off schedule");

	blink_bound_a: assert property ( // R24
		st_reg.slow_cnt < 32'(SLOW_HALF_CYCLES) && st_reg.fast_cnt < 32'(FAST_HALF_CYCLES))
		else $error("blink counter out of range");

	slow_wrap_a: assert property ( // R24
		$past(st_reg.slow_cnt) == 32'(SLOW_HALF_CYCLES - 1) |-> st_reg.slow_cnt == 32'h0)
		else $error("slow blink counter did not wrap");

	busy_hold_a: assert property ( // R20
		st_reg.busy && st_reg.fill_cnt != 32'(FILL_CYCLES - 1) |=> disp.fill_busy)
		else $error("fill ended early");

	fill_end_a: assert property ( // R20 R21
		st_reg.busy && st_reg.fill_cnt == 32'(FILL_CYCLES - 1)
		&& !(st_reg.wr_pend && st_reg.wr_sel == dcr_pkg::SEL_FILLCMD)
		|=> !disp.fill_busy && !disp.fill_done_irq_n)
		else $error("fill did not end on time");

	fill_idle_a: assert property ( // R19
		!st_reg.busy && !(st_reg.wr_pend && st_reg.wr_sel == dcr_pkg::SEL_FILLCMD)
		|=> !disp.fill_busy)
		else $error("fill started without a command");

	busy_out_a: assert property ( // R20
		disp.fill_busy == st_reg.busy)
		else $error("busy output disagrees with state");

	fill_bound_a: assert property ( // R20
		st_reg.fill_cnt < 32'(FILL_CYCLES))
		else $error("fill counter out of range");

	irq_hold_a: assert property ( // R21
		st_reg.irq_cnt > 32'h1 |=> !disp.fill_done_irq_n)
		else $error("interrupt released early");

	irq_end_a: assert property ( // R21
		st_reg.irq_cnt == 32'h1 && !st_reg.busy |=> disp.fill_done_irq_n)
		else $error("interrupt held too long");

	pwm_wrap_a: assert property ( // R14
		st_reg.pwm_cnt <= dcr_pkg::PWM_LAST)
		else $error("pwm counter out of range");

	pwm_level_a: assert property ( // R14
		disp.backlight_pwm == ($past(st_reg.pwm_cnt) < $past(st_reg.duty)))
		else $error("pwm level disagrees with duty");

	adc_hold_a: assert property ( // R8
		!adc_strobe |=> $stable(st_reg.adc_x) && $stable(st_reg.adc_y))
		else $error("touch result changed without strobe");

	pend_only_a: assert property ( // R19
		!acc |=> !st_reg.wr_pend)
		else $error("write pending without a transfer");
endmodule
`default_nettype wire

// *** verification/dcr_host.sv ***
// Host bus master model issuing single AHB-Lite word transfers to the display control registers.
`timescale 1ns/100ps
`default_nettype none
module dcr_host (
	input  wire logic        hclk,
	input  wire logic        hreadyout,
	input  wire logic [31:0] hrdata,
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// Data lines are scrambled once a phase ends so a stale word never looks valid.
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		hwdata <= ~hwdata;
	endtask
	// Fill and write pages are programmed alike before any fill starts.
	task automatic fill_start(input logic [1:0] pg);
		logic [31:0] q;
		xfer({dcr_pkg::IDX_PAGE, 2'b00}, 1'b1, {26'h0, pg, 2'h0, pg}, q);
		xfer({dcr_pkg::IDX_FILLCMD, 2'b00}, 1'b1, 32'h0, q);
	endtask
endmodule
`default_nettype wire

// *** verification/test_display_control_registers.sv ***
// Self-checking testbench of the display control register bank.
`timescale 1ns/100ps
`default_nettype none
module test_display_control_registers;
	localparam int          FILL   = 20;
	localparam logic [31:0] A_DUTY = {dcr_pkg::IDX_DUTY, 2'b00};
	localparam logic [31:0] A_ORI  = {dcr_pkg::IDX_ORIENT, 2'b00};
	localparam logic [31:0] A_LAY  = {dcr_pkg::IDX_LAYER, 2'b00};
	localparam logic [31:0] A_PAGE = {dcr_pkg::IDX_PAGE, 2'b00};
	localparam logic [31:0] A_PIX  = {dcr_pkg::IDX_FILLPIX, 2'b00};
	localparam logic [31:0] A_CMD  = {dcr_pkg::IDX_FILLCMD, 2'b00};
	logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, adc_strobe;
	logic [31:0]        haddr, hwdata, hrdata, q;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic [7:0]         adc_x, adc_y;
	dcr_pkg::dcr_disp_t disp;
	int                 miscompares = 0, n_checks = 0, cycles = 0, k, f, s;
	dcr_regs #(.FILL_CYCLES(FILL), .SLOW_HALF_CYCLES(16), .FAST_HALF_CYCLES(8)) u_dcr_regs (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .adc_strobe(adc_strobe), .adc_x_in(adc_x), .adc_y_in(adc_y), .disp(disp));
	dcr_host u_dcr_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// The whole run needs about 3300 cycles, so the ceiling leaves ample margin.
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		u_dcr_host.xfer(a, 1'b1, d, q);
		@(negedge hclk);
	endtask
	task automatic rd(input logic [31:0] a);
		u_dcr_host.xfer(a, 1'b0, 32'h0, q);
	endtask
	task automatic pwm_count();
		k = 0;
		repeat (127) begin
			@(negedge hclk);
			k += disp.backlight_pwm;
		end
	endtask
	task automatic toggles();
		logic pf, ps;
		f = 0;
		s = 0;
		pf = disp.fast_show;
		ps = disp.slow_show;
		repeat (64) begin
			@(negedge hclk);
			f += (disp.fast_show !== pf);
			s += (disp.slow_show !== ps);
			pf = disp.fast_show;
			ps = disp.slow_show;
		end
	endtask
	task automatic t_reset();
		check("orient rst", {disp.flip_ud, disp.flip_rl, disp.backlight_on}, 3'h5);
		check("show rst", {disp.color_mode, disp.fast_show, disp.slow_show}, 3'h3);
		pwm_count();
		check("pwm rst", k, 127);
		rd(A_DUTY);
		check("duty rd", q, 32'h0);
		rd(32'h100);
		check("unmapped rd", q, 32'h0);
		check("bus idle", {hreadyout, hresp}, 2'h2);
		$display("test reset done");
	endtask
	task automatic t_layer();
		wr(A_LAY, 32'h9e);
		check("layer a", {disp.color_mode, disp.transp_active, disp.bg_page, disp.fg_page}, 6'h2e);
		wr(A_LAY, 32'h15);
		check("layer b", {disp.color_mode, disp.transp_active, disp.bg_page, disp.fg_page}, 6'h15);
		wr(A_PAGE, 32'hffffff26);
		check("page", {disp.fill_page, disp.read_page, disp.write_page}, 6'h26);
		for (int i = 0; i < 8; i++) begin
			wr(A_ORI, i);
			check("orient", {disp.flip_ud, disp.flip_rl, disp.backlight_on}, i[2:0]);
		end
		$display("test layer done");
	endtask
	task automatic t_adc();
		for (int i = 0; i < 2; i++) begin
			@(posedge hclk);
			adc_strobe <= 1'b1;
			adc_x <= 8'ha5 ^ {8{i[0]}};
			adc_y <= 8'h3c ^ {8{i[0]}};
			@(posedge hclk);
			adc_strobe <= 1'b0;
			rd(A_LAY);
			check("adc x", q, 32'ha5 ^ {24'h0, {8{i[0]}}});
			rd(A_PAGE);
			check("adc y", q, 32'h3c ^ {24'h0, {8{i[0]}}});
		end
		$display("test adc done");
	endtask
	task automatic t_blink();
		wr(A_LAY, 32'h60);
		toggles();
		check("fast toggles", f, 8);
		check("slow toggles", s, 4);
		wr(A_LAY, 32'h20);
		toggles();
		check("fast off", {f[7:0], disp.fast_show}, 9'h1);
		check("slow only", s, 4);
		$display("test blink done");
	endtask
	task automatic t_duty();
		wr(A_DUTY, 32'h0);
		pwm_count();
		check("pwm 00", k, 0);
		wr(A_DUTY, 32'h40);
		pwm_count();
		check("pwm 40", k, 64);
		$display("test duty done");
	endtask
	task automatic t_fill();
		wr(A_PIX, 32'hc5);
		check("fill pixel", disp.fill_pixel, 8'hc5);
		u_dcr_host.fill_start(2'h1);
		k = 0;
		@(negedge hclk);
		while (disp.fill_busy === 1'b1 && k < 100) begin
			k++;
			@(negedge hclk);
		end
		check("busy cycles", k, FILL);
		check("pages", {disp.fill_page, disp.write_page}, 4'h5);
		k = 0;
		while (disp.fill_done_irq_n === 1'b0 && k < 3000) begin
			k++;
			@(negedge hclk);
		end
		check("irq cycles", k, dcr_pkg::IRQ_CYCLES);
		rd(A_CMD);
		check("busy idle", q, 32'h0);
		u_dcr_host.fill_start(2'h0);
		rd(A_CMD);
		check("busy set", q, 32'h1);
		$display("test fill done");
	endtask
	initial begin
		hresetn = 1'b0;
		adc_strobe = 1'b0;
		adc_x = 8'h0;
		adc_y = 8'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		t_reset();
		t_layer();
		t_adc();
		t_blink();
		t_duty();
		t_fill();
		stop_test();
	end
endmodule
`default_nettype wire
